// *** logic/timer32_pkg.sv ***
// Constants, register map and field layout of the 32-bit general-purpose timer
// =====================================================================
// Functional notes
// R1: 32-bit up/down counter fed by prescaler
// R2: Prescaler codes divide by 1, 16, 256, 32768
// R3: Clock select: oscillator, core, PLL, pin
// R4: Format 00 binary, 10 time-of-day 23 hours
// R5: Format 11 time format, hours 255 down
// R6: Config bit 7 enables counting, reset clear
// R7: Config bit 6 periodic, else free-running
// R8: Config bit 8 counts up, else down
// R9: Reload on overflow when periodic, and on clear write
// R10: Clear register write deasserts timer interrupt
// R11: Config bit 17 enables event capture
// R12: Five-bit field selects capture source 0-16
// R13: Selected source rising copies count, keeps running
// R14: Post-scaler bits 31:24 written only with bit 23
// R15: Bit 19 compare flag, bit 18 interrupt select
// R16: Pin or oscillator source runs in low power
// R17: Live count register reads counter, resets zero
// R18: Post-scaler counts timeouts, flags match, selects interrupt
// R19: Config bits 22:20 read zero, ignore writes
package timer32_pkg;

  // =====================================================================
  // Register byte addresses
  localparam logic [31:0] ADDR_RELOAD = 32'hffff0320;
  localparam logic [31:0] ADDR_LIVE = 32'hffff0324;
  localparam logic [31:0] ADDR_CONFIG = 32'hffff0328;
  localparam logic [31:0] ADDR_CLEAR = 32'hffff032c;
  localparam logic [31:0] ADDR_CAPTURE = 32'hffff0330;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hffff0334;
  localparam logic [31:0] ADDR_IRQ_CLEAR = 32'hffff0338;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hffff033c;

  // =====================================================================
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] RESET_IRQ = 3'h0;

  // =====================================================================
  // Field codes
  localparam logic [3:0] PRESC_DIV16 = 4'h4;
  localparam logic [3:0] PRESC_DIV256 = 4'h8;
  localparam logic [3:0] PRESC_DIV32768 = 4'hf;
  localparam logic [14:0] LIMIT_DIV1 = 15'h0000;
  localparam logic [14:0] LIMIT_DIV16 = 15'h000f;
  localparam logic [14:0] LIMIT_DIV256 = 15'h00ff;
  localparam logic [14:0] LIMIT_DIV32768 = 15'h7fff;
  localparam logic [2:0] CLK_OSC = 3'h0;
  localparam logic [2:0] CLK_CORE = 3'h1;
  localparam logic [2:0] CLK_PLL = 3'h2;
  localparam logic [2:0] CLK_PIN = 3'h3;
  localparam logic [1:0] FMT_DAY = 2'h2;
  localparam logic [1:0] FMT_LONG = 2'h3;
  localparam logic [4:0] EVENT_LAST = 5'h10;
  localparam int NUM_EVENTS = 17;

  // =====================================================================
  // Time-of-day field limits
  localparam logic [6:0] HUN_MAX = 7'h63;
  localparam logic [5:0] MIN_SEC_MAX = 6'h3b;
  localparam logic [7:0] HR_MAX_DAY = 8'h17;
  localparam logic [7:0] HR_MAX_LONG = 8'hff;

  // =====================================================================
  // Interrupt status bit positions
  localparam int IRQ_TIMER = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_POSTSCALE = 2;

  // Configuration word layout
  typedef struct packed {
    logic [7:0] postscale;
    logic postscale_wr_en;
    logic [2:0] reserved;
    logic postscale_flag;
    logic irq_on_match;
    logic capture_en;
    logic [4:0] event_sel;
    logic [2:0] clk_sel;
    logic count_up;
    logic enable;
    logic periodic;
    logic [1:0] format;
    logic [3:0] prescale;
  } timer_config_t;

endpackage

// *** logic/timer32.sv ***
// 32-bit general-purpose timer with capture, post-scaler and Wishbone registers
`timescale 1ns/1ps
module timer32
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Counter clock sources, sampled on sys_clk
  input wire logic low_power_osc,
  input wire logic undivided_pll_clock,
  input wire logic external_clock_pin,
  input wire logic low_power_mode,
  // Capture trigger sources
  input wire logic [16:0] event_sources,
  // Interrupt
  output logic irq
);

  // =====================================================================
  // Functions
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        m[b*8 +: 8] = nw[b*8 +: 8];
    end
    return m;
  endfunction

  function automatic logic [14:0] presc_limit(input logic [3:0] code);
    logic [14:0] l;
    case (code)
      timer32_pkg::PRESC_DIV16: l = timer32_pkg::LIMIT_DIV16;
      timer32_pkg::PRESC_DIV256: l = timer32_pkg::LIMIT_DIV256;
      timer32_pkg::PRESC_DIV32768: l = timer32_pkg::LIMIT_DIV32768;
      default: l = timer32_pkg::LIMIT_DIV1;
    endcase
    return l;
  endfunction

  // Returns {wrapped, next value} for the time-of-day format
  function automatic logic [32:0] hms_step(input logic [31:0] v, input logic up,
                                           input logic [7:0] hmax);
    logic [7:0] hr;
    logic [5:0] mn;
    logic [5:0] sc;
    logic [6:0] hu;
    logic wrap;
    hr = v[31:24];
    mn = v[21:16];
    sc = v[13:8];
    hu = v[6:0];
    wrap = 1'b0;
    if (up)
    begin
      if (hu < timer32_pkg::HUN_MAX)
        hu = hu + 7'h01;
      else
      begin
        hu = 7'h00;
        if (sc < timer32_pkg::MIN_SEC_MAX)
          sc = sc + 6'h01;
        else
        begin
          sc = 6'h00;
          if (mn < timer32_pkg::MIN_SEC_MAX)
            mn = mn + 6'h01;
          else
          begin
            mn = 6'h00;
            if (hr < hmax)
              hr = hr + 8'h01;
            else
            begin
              hr = 8'h00;
              wrap = 1'b1;
            end
          end
        end
      end
    end
    else
    begin
      if (hu != 7'h00)
        hu = hu - 7'h01;
      else
      begin
        hu = timer32_pkg::HUN_MAX;
        if (sc != 6'h00)
          sc = sc - 6'h01;
        else
        begin
          sc = timer32_pkg::MIN_SEC_MAX;
          if (mn != 6'h00)
            mn = mn - 6'h01;
          else
          begin
            mn = timer32_pkg::MIN_SEC_MAX;
            if (hr != 8'h00)
              hr = hr - 8'h01;
            else
            begin
              hr = hmax;
              wrap = 1'b1;
            end
          end
        end
      end
    end
    return {wrap, hr, 2'b00, mn, 2'b00, sc, 1'b0, hu};
  endfunction

  // =====================================================================
  // Declarations
  timer32_pkg::timer_config_t cfg_r, cfg_wr;
  logic [31:0] reload_r, count_r, count_nxt, capture_r, stepped;
  logic [14:0] presc_r;
  logic [7:0] post_cnt_r;
  logic [2:0] src_prev_r, src_rise, irq_sts_r, irq_en_r, irq_set;
  logic [16:0] event_prev_r;
  logic [32:0] hms;
  logic post_flag_r, src_tick, src_allowed, tick, wrap, timeout, post_match, capture_hit;
  logic bus_req, wr_en, wr_reload, wr_config, wr_clear, wr_irq_clear, wr_irq_enable;

  // =====================================================================
  // Bus decode
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i;
  assign wr_reload = wr_en && (wb_adr_i == timer32_pkg::ADDR_RELOAD);
  assign wr_config = wr_en && (wb_adr_i == timer32_pkg::ADDR_CONFIG);
  assign wr_clear = wr_en && (wb_adr_i == timer32_pkg::ADDR_CLEAR);
  assign wr_irq_clear = wr_en && (wb_adr_i == timer32_pkg::ADDR_IRQ_CLEAR);
  assign wr_irq_enable = wr_en && (wb_adr_i == timer32_pkg::ADDR_IRQ_ENABLE);
  assign cfg_wr = timer32_pkg::timer_config_t'(merge(32'h0000_0000, wb_dat_i, wb_sel_i));

  // Ack is one cycle long; a held request is taken again only after ack drops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // =====================================================================
  // Register writes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reload_r <= timer32_pkg::RESET_WORD;
    else if (wr_reload)
      reload_r <= merge(reload_r, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cfg_r <= timer32_pkg::timer_config_t'(timer32_pkg::RESET_WORD);
    else if (wr_config)
    begin
      if (wb_sel_i[0])
      begin
        cfg_r.prescale <= cfg_wr.prescale; // see R2
        cfg_r.format <= cfg_wr.format; // see R4
        cfg_r.periodic <= cfg_wr.periodic; // see R7
        cfg_r.enable <= cfg_wr.enable; // see R6
      end
      if (wb_sel_i[1])
      begin
        cfg_r.count_up <= cfg_wr.count_up; // see R8
        cfg_r.clk_sel <= cfg_wr.clk_sel; // see R3
        cfg_r.event_sel[3:0] <= cfg_wr.event_sel[3:0]; // see R12
      end
      if (wb_sel_i[2])
      begin
        cfg_r.event_sel[4] <= cfg_wr.event_sel[4]; // see R12
        cfg_r.capture_en <= cfg_wr.capture_en; // see R11
        cfg_r.irq_on_match <= cfg_wr.irq_on_match; // see R15
      end
      // Post-scaler field only moves when its write enable rides in the same write
      if (wb_sel_i[3] && wb_sel_i[2] && cfg_wr.postscale_wr_en)
        cfg_r.postscale <= cfg_wr.postscale; // see R14
      // Reserved bits, the flag and the write enable are never stored
      cfg_r.reserved <= 3'h0; // see R19
      cfg_r.postscale_flag <= 1'b0;
      cfg_r.postscale_wr_en <= 1'b0;
    end
  end

  // =====================================================================
  // Clock source selection and prescaler
  // Pin and oscillator inputs are synchronous; a rising level is one source tick
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      src_prev_r <= 3'h0;
    else
      src_prev_r <= {external_clock_pin, undivided_pll_clock, low_power_osc};
  end

  assign src_rise = {external_clock_pin, undivided_pll_clock, low_power_osc} & ~src_prev_r;

  always_comb
  begin
    case (cfg_r.clk_sel) // see R3
      timer32_pkg::CLK_OSC: src_tick = src_rise[0];
      timer32_pkg::CLK_CORE: src_tick = 1'b1;
      timer32_pkg::CLK_PLL: src_tick = src_rise[1];
      timer32_pkg::CLK_PIN: src_tick = src_rise[2];
      default: src_tick = 1'b0;
    endcase
  end

  // Core and PLL clocks stop in low power; pin and oscillator keep counting
  assign src_allowed = !low_power_mode || (cfg_r.clk_sel == timer32_pkg::CLK_OSC)
                       || (cfg_r.clk_sel == timer32_pkg::CLK_PIN); // see R16

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      presc_r <= 15'h0000;
    else if (!cfg_r.enable || wr_clear)
      presc_r <= 15'h0000;
    else if (src_tick && src_allowed)
    begin
      if (presc_r >= presc_limit(cfg_r.prescale))
        presc_r <= 15'h0000; // see R2
      else
        presc_r <= presc_r + 15'h0001;
    end
  end

  assign tick = cfg_r.enable && src_tick && src_allowed
                && (presc_r >= presc_limit(cfg_r.prescale)); // see R6

  // =====================================================================
  // Counter
  always_comb
  begin
    hms = hms_step(count_r, cfg_r.count_up,
                   (cfg_r.format == timer32_pkg::FMT_LONG) ? timer32_pkg::HR_MAX_LONG
                                                           : timer32_pkg::HR_MAX_DAY);
    if (cfg_r.format == timer32_pkg::FMT_DAY || cfg_r.format == timer32_pkg::FMT_LONG)
    begin
      wrap = hms[32]; // see R4, R5
      stepped = hms[31:0];
    end
    else if (cfg_r.count_up)
    begin
      wrap = &count_r; // see R8
      stepped = count_r + 32'h0000_0001;
    end
    else
    begin
      wrap = (count_r == 32'h0000_0000);
      stepped = count_r - 32'h0000_0001; // see R1
    end
  end

  assign timeout = tick && wrap;

  always_comb
  begin
    count_nxt = count_r;
    if (wr_clear)
      count_nxt = reload_r; // see R9
    else if (timeout && cfg_r.periodic)
      count_nxt = reload_r; // see R7, R9
    else if (tick)
      count_nxt = stepped;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      count_r <= timer32_pkg::RESET_WORD; // see R17
    else
      count_r <= count_nxt;
  end

  // =====================================================================
  // Post-scaler
  assign post_match = timeout && (post_cnt_r == cfg_r.postscale); // see R18

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      post_cnt_r <= 8'h00;
    else if (wr_clear || post_match)
      post_cnt_r <= 8'h00;
    else if (timeout)
      post_cnt_r <= post_cnt_r + 8'h01; // see R18
  end

  // A match in the same cycle as a clear write is kept
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      post_flag_r <= 1'b0;
    else if (post_match)
      post_flag_r <= 1'b1; // see R15
    else if (wr_clear)
      post_flag_r <= 1'b0;
  end

  // =====================================================================
  // Event capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      event_prev_r <= 17'h00000;
    else
      event_prev_r <= event_sources;
  end

  assign capture_hit = cfg_r.capture_en && (cfg_r.event_sel <= timer32_pkg::EVENT_LAST)
                       && event_sources[cfg_r.event_sel]
                       && !event_prev_r[cfg_r.event_sel]; // see R11, R12

  // Counting continues; only the snapshot is taken
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      capture_r <= timer32_pkg::RESET_WORD;
    else if (capture_hit)
      capture_r <= count_r; // see R13
  end

  // =====================================================================
  // Interrupts
  assign irq_set[timer32_pkg::IRQ_TIMER] = cfg_r.irq_on_match ? post_match : timeout; // see R18
  assign irq_set[timer32_pkg::IRQ_CAPTURE] = capture_hit;
  assign irq_set[timer32_pkg::IRQ_POSTSCALE] = post_match;

  // Set wins over clear so a timeout in the clearing cycle is not lost
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_sts_r <= timer32_pkg::RESET_IRQ;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (irq_set[i])
          irq_sts_r[i] <= 1'b1;
        else if (wr_irq_clear && wb_sel_i[0] && wb_dat_i[i])
          irq_sts_r[i] <= 1'b0;
        else if (wr_clear && i == timer32_pkg::IRQ_TIMER)
          irq_sts_r[i] <= 1'b0; // see R10
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_en_r <= timer32_pkg::RESET_IRQ;
    else if (wr_irq_enable && wb_sel_i[0])
      irq_en_r <= wb_dat_i[2:0];
  end

  // Registered output lags the status bit by one cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_sts_r & irq_en_r);
  end

  // =====================================================================
  // Read data
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wb_dat_o <= timer32_pkg::RESET_WORD;
    else if (bus_req && !wb_we_i)
    begin
      case (wb_adr_i)
        timer32_pkg::ADDR_RELOAD: wb_dat_o <= reload_r;
        timer32_pkg::ADDR_LIVE: wb_dat_o <= count_r; // see R17
        timer32_pkg::ADDR_CONFIG: wb_dat_o <= {cfg_r.postscale, 4'h0, post_flag_r,
                                               cfg_r[18:0]}; // see R15, R19
        timer32_pkg::ADDR_CAPTURE: wb_dat_o <= capture_r;
        timer32_pkg::ADDR_IRQ_STATUS: wb_dat_o <= {29'h0000_0000, irq_sts_r};
        timer32_pkg::ADDR_IRQ_ENABLE: wb_dat_o <= {29'h0000_0000, irq_en_r};
        default: wb_dat_o <= timer32_pkg::RESET_WORD;
      endcase
    end
    else
      wb_dat_o <= timer32_pkg::RESET_WORD;
  end

endmodule

// *** testbench/timer32_monitor.sv ***
// Port checker for the 32-bit general-purpose timer
`timescale 1ns/1ps
module timer32_monitor
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Interrupt
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // =====================================================================
  // Request decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  sequence s_rd(logic [31:0] a);
    req && !wb_we_i && wb_adr_i == a;
  endsequence

  sequence s_mask_all;
    req && wb_we_i && wb_adr_i == timer32_pkg::ADDR_IRQ_ENABLE && wb_sel_i[0] &&
      wb_dat_i[2:0] == 3'h0;
  endsequence

  // =====================================================================
  // Properties
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_next;
    req |=> wb_ack_o;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(req);
  endproperty
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  property p_wo_zero;
    s_rd(timer32_pkg::ADDR_CLEAR) |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  property p_unmapped;
    s_rd(32'hffff0340) |=> wb_dat_o == 32'h0;
  endproperty
  property p_cfg_rsvd;
    s_rd(timer32_pkg::ADDR_CONFIG) |=> wb_dat_o[23:20] == 4'h0;
  endproperty
  property p_irq_reset;
    $past(rst) |-> !irq && !wb_ack_o;
  endproperty
  // Irq is registered behind the enable, so masking shows two edges on
  property p_irq_mask;
    s_mask_all |=> ##1 !irq;
  endproperty

  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_wo_zero: assert property (p_wo_zero) else $error("clear register read not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved bits not zero");
  a_irq_reset: assert property (p_irq_reset) else $error("irq or ack after reset");
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the 32-bit general-purpose timer
`timescale 1ns/1ps
module tb_top;
  // =====================================================================
  // Signals and counters
  logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, low_power_mode;
  logic low_power_osc, undivided_pll_clock, external_clock_pin;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [16:0] event_sources;
  int mismatches = 0;
  int total_checks = 0;

  always #25 sys_clk = ~sys_clk;

  timer32 i_dut
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .low_power_osc(low_power_osc),
    .undivided_pll_clock(undivided_pll_clock),
    .external_clock_pin(external_clock_pin),
    .low_power_mode(low_power_mode),
    .event_sources(event_sources),
    .irq(irq)
  );

  // =====================================================================
  // Shared tasks
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Waits on ack with no bound of its own; the watchdog ends a dead slave
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    check("ack latency", 32'(n), 32'h2);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    check(n, rd, e);
  endtask

  task automatic load(input logic [31:0] v);
    wr(timer32_pkg::ADDR_RELOAD, v);
    wr(timer32_pkg::ADDR_CLEAR, 32'h0);
  endtask

  function automatic logic [31:0] cfg(input int c, u, e, p, f, ps);
    return 32'(c * 512 + u * 256 + e * 128 + p * 64 + f * 16 + ps);
  endfunction

  // All three sampled sources rise together; only the selected one counts
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      {low_power_osc, undivided_pll_clock, external_clock_pin} <= 3'h7;
      repeat (2) @(posedge sys_clk);
      {low_power_osc, undivided_pll_clock, external_clock_pin} <= 3'h0;
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic ev(input int k);
    @(posedge sys_clk);
    event_sources[k] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    event_sources[k] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 9; i++)
      rdc("reset value", 32'hffff0320 + 32'(4 * i), 32'h0);
  endtask

  task automatic t_regs;
    wr(timer32_pkg::ADDR_RELOAD, 32'h1234_5678);
    bus(1'b1, timer32_pkg::ADDR_RELOAD, 32'haaaa_aaaa, 4'h3);
    rdc("reload lanes", timer32_pkg::ADDR_RELOAD, 32'h1234_aaaa);
    wr(timer32_pkg::ADDR_CONFIG, 32'hab70_0000);
    rdc("config guard", timer32_pkg::ADDR_CONFIG, 32'h0);
    wr(timer32_pkg::ADDR_CONFIG, 32'hab80_0000);
    rdc("postscale", timer32_pkg::ADDR_CONFIG, 32'hab00_0000);
    bus(1'b1, timer32_pkg::ADDR_CONFIG, 32'hcd80_0000, 4'h7);
    rdc("postscale lanes", timer32_pkg::ADDR_CONFIG, 32'hab00_0000);
    wr(timer32_pkg::ADDR_LIVE, 32'h5);
    rdc("live read only", timer32_pkg::ADDR_LIVE, 32'h0);
  endtask

  task automatic t_sources;
    logic [31:0] e;
    for (int s = 0; s < 4; s++)
      for (int lp = 0; lp < 2; lp++)
      begin
        if (s == 1 && lp == 0)
          continue;
        @(posedge sys_clk);
        low_power_mode <= lp[0];
        load(32'd1000);
        wr(timer32_pkg::ADDR_CONFIG, cfg(s, 1, 1, 0, 0, 0));
        pulse(5);
        wr(timer32_pkg::ADDR_CONFIG, cfg(s, 1, 0, 0, 0, 0));
        e = (s == 0 || s == 3 || lp == 0) ? 32'd1005 : 32'd1000;
        rdc("source count", timer32_pkg::ADDR_LIVE, e);
      end
    low_power_mode <= 1'b0;
  endtask

  task automatic t_prescale;
    int c [4] = '{0, 4, 8, 15};
    int w [4] = '{40, 320, 2560, 40000};
    int dv [4] = '{1, 16, 256, 32768};
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      load(32'h0001_0000);
      wr(timer32_pkg::ADDR_CONFIG, cfg(1, 0, 1, 0, 0, c[i]));
      repeat (w[i]) @(posedge sys_clk);
      wr(timer32_pkg::ADDR_CONFIG, cfg(1, 0, 0, 0, 0, c[i]));
      bus(1'b0, timer32_pkg::ADDR_LIVE, 32'h0, 4'hf);
      d = 32'h0001_0000 - rd;
      check("prescale", 32'(d >= w[i] / dv[i] && d <= (w[i] + 16) / dv[i]), 32'h1);
    end
  endtask

  task automatic t_format;
    int f [4] = '{0, 0, 2, 3};
    int p [4] = '{0, 1, 0, 0};
    int ld [4] = '{1, 1, 0, 0};
    logic [31:0] e [4] = '{32'hffff_ffff, 32'h1, 32'h173b_3b63, 32'hff3b_3b63};
    for (int i = 0; i < 4; i++)
    begin
      load(32'(ld[i]));
      wr(timer32_pkg::ADDR_CONFIG, cfg(0, 0, 1, p[i], f[i], 0));
      pulse(ld[i] + 1);
      wr(timer32_pkg::ADDR_CONFIG, cfg(0, 0, 0, p[i], f[i], 0));
      rdc("wrap", timer32_pkg::ADDR_LIVE, e[i]);
    end
  endtask

  task automatic t_irq;
    wr(timer32_pkg::ADDR_IRQ_ENABLE, 32'h1);
    load(32'h1);
    wr(timer32_pkg::ADDR_CONFIG, cfg(0, 0, 1, 1, 0, 0));
    pulse(2);
    wr(timer32_pkg::ADDR_CONFIG, 32'h0);
    rdc("timeout status", timer32_pkg::ADDR_IRQ_STATUS, 32'h1);
    check("irq set", {31'h0, irq}, 32'h1);
    wr(timer32_pkg::ADDR_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge sys_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(timer32_pkg::ADDR_IRQ_ENABLE, 32'h1);
    wr(timer32_pkg::ADDR_RELOAD, 32'h9);
    wr(timer32_pkg::ADDR_CLEAR, 32'h5a);
    repeat (2) @(posedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc("status cleared", timer32_pkg::ADDR_IRQ_STATUS, 32'h0);
    rdc("clear reload", timer32_pkg::ADDR_LIVE, 32'h9);
  endtask

  task automatic t_postscale;
    load(32'h0);
    wr(timer32_pkg::ADDR_CONFIG, 32'h0184_00c0);
    pulse(1);
    rdc("no match status", timer32_pkg::ADDR_IRQ_STATUS, 32'h0);
    pulse(1);
    rdc("match status", timer32_pkg::ADDR_IRQ_STATUS, 32'h5);
    rdc("match flag", timer32_pkg::ADDR_CONFIG, 32'h010c_00c0);
    check("match irq", {31'h0, irq}, 32'h1);
    wr(timer32_pkg::ADDR_CONFIG, 32'h0);
    wr(timer32_pkg::ADDR_CLEAR, 32'h0);
    rdc("flag cleared", timer32_pkg::ADDR_CONFIG, 32'h0100_0000);
    rdc("match left", timer32_pkg::ADDR_IRQ_STATUS, 32'h4);
    wr(timer32_pkg::ADDR_IRQ_CLEAR, 32'h4);
  endtask

  task automatic t_capture;
    load(32'd77);
    wr(timer32_pkg::ADDR_CONFIG, 32'h0003_0000);
    ev(5);
    rdc("other source", timer32_pkg::ADDR_CAPTURE, 32'h0);
    ev(16);
    rdc("capture", timer32_pkg::ADDR_CAPTURE, 32'd77);
    rdc("capture status", timer32_pkg::ADDR_IRQ_STATUS, 32'h2);
    wr(timer32_pkg::ADDR_IRQ_CLEAR, 32'h2);
    rdc("status clear", timer32_pkg::ADDR_IRQ_STATUS, 32'h0);
    wr(timer32_pkg::ADDR_CONFIG, 32'h0001_0000);
    load(32'd99);
    ev(16);
    rdc("capture off", timer32_pkg::ADDR_CAPTURE, 32'd77);
  endtask

  // =====================================================================
  // Main sequence and watchdog
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, low_power_mode} = 4'h0;
    {low_power_osc, undivided_pll_clock, external_clock_pin} = 3'h0;
    wb_sel_i = 4'h0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    event_sources = 17'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_sources();
    t_prescale();
    t_format();
    t_irq();
    t_postscale();
    t_capture();
    finish_test();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
endmodule

bind timer32 timer32_monitor i_mon
(
  .sys_clk(sys_clk),
  .rst(rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .irq(irq)
);
